// ---- logic/fsss_cfg.svh ----
// timing counts, code values and reset values for the supply supervisor
`ifndef FSSS_CFG_SVH
`define FSSS_CFG_SVH
`define FSSS_CLK_HZ         40000000
`define FSSS_RST_PULSE_US   1000
`define FSSS_WD_PERIOD_MS   256
`define FSSS_CLAMP_MS       100
`define FSSS_IDLE_S         8
`define FSSS_RST_PULSE_CYC  ((`FSSS_CLK_HZ / 1000000) * `FSSS_RST_PULSE_US)
`define FSSS_WD_PERIOD_CYC  ((`FSSS_CLK_HZ / 1000) * `FSSS_WD_PERIOD_MS)
`define FSSS_CLAMP_CYC      ((`FSSS_CLK_HZ / 1000) * `FSSS_CLAMP_MS)
`define FSSS_IDLE_CYC       (`FSSS_CLK_HZ * `FSSS_IDLE_S)
`define FSSS_WD_FAIL_LIMIT  4'h8
`define FSSS_CODE_A         3'h7
`define FSSS_CODE_B1        3'h6
`define FSSS_CODE_B2        3'h5
`define FSSS_CODE_B3        3'h4
`define FSSS_HOLD_RESET     1'h0
`define FSSS_REL_CMD0       16'hDD00
`define FSSS_REL_CMD1       16'hDD80
`endif

// ---- logic/fsss_pkg.sv ----
// types shared by the supply supervisor modules
package fsss_pkg;
	typedef enum logic [2:0] {
		FSSS_ST_INIT   = 3'b000,
		FSSS_ST_NORMAL = 3'b001,
		FSSS_ST_RESET  = 3'b010,
		FSSS_ST_NREQ   = 3'b011,
		FSSS_ST_SAFE_ON  = 3'b100,
		FSSS_ST_SAFE_OFF = 3'b101
	} fsss_state_t;
endpackage

// ---- logic/fsss_mon_if.sv ----
// events passed from the external-event monitor to the supervisor
`timescale 1ns/1ps
interface fsss_mon_if;
	logic idle_expired;
	logic pin_low_seen;
	logic arm;
	modport mon (input arm, output idle_expired, output pin_low_seen);
	modport sup (output arm, input idle_expired, input pin_low_seen);
endinterface

// ---- logic/fsss_event_mon.sv ----
// bus-idle timer and io pin high-to-low watcher used in the b safe modes
`timescale 1ns/1ps
`include "fsss_cfg.svh"
module fsss_event_mon import fsss_pkg::*; #(
	parameter int unsigned IDLE_CYC = `FSSS_IDLE_CYC
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic bus_activity_i,
	input  wire logic io1_level_i,
	fsss_mon_if.mon   m
);
	logic [31:0] idle_cnt_r;
	logic        io1_prev_r;
	logic        idle_exp_r;
	logic        low_seen_r;

	// any traffic restarts the full interval
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			idle_cnt_r <= 32'h0;
			idle_exp_r <= 1'b0;
		end else if (!m.arm || bus_activity_i) begin
			idle_cnt_r <= 32'h0;
			idle_exp_r <= 1'b0;
		end else if (idle_cnt_r >= IDLE_CYC - 1) begin
			idle_exp_r <= 1'b1;
		end else begin
			idle_cnt_r <= idle_cnt_r + 32'h1;
		end
	end

	// falling edge or already-low level counts, so a pin low at entry is not missed
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			io1_prev_r <= 1'b1;
			low_seen_r <= 1'b0;
		end else begin
			io1_prev_r <= io1_level_i;
			if (!m.arm)
				low_seen_r <= 1'b0;
			else if ((io1_prev_r && !io1_level_i) || !io1_level_i)
				low_seen_r <= 1'b1;
		end
	end

	assign m.idle_expired = idle_exp_r;
	assign m.pin_low_seen = low_seen_r;
endmodule

// ---- logic/fsss_supervisor.sv ----
// supply hold and fail-safe state machine of the supervisor
// Summary of operation
// - hold bit resets 0; supply on above threshold
// - hold 0: supply off in reset when low
// - hold 1: supply stays until battery fail
// - safe output low while in safe mode
// - latch debug code at init exit; override wins
// - code 111: mode a, supply stays on
// - code 110: b1, off after idle timeout
// - code 101: b2, off on pin low
// - code 100: b3, needs idle and pin low
// - safe at first or second reset pulse
// - supply low: safe with reset together
// - reset clamped 100 ms enters safe mode
// - eight watchdog failures start safe evaluation
// - 1 ms reset pulse every 256 ms
// - recovery leaves safe output low
// - wake-up restores supply, enters reset
// - safe held until release command after clear
// - b modes use 8 s idle, pin fall
`timescale 1ns/1ps
`include "fsss_cfg.svh"
module fsss_supervisor import fsss_pkg::*; #(
	parameter int unsigned IDLE_CYC    = `FSSS_IDLE_CYC,
	parameter int unsigned WD_PER_CYC  = `FSSS_WD_PERIOD_CYC,
	parameter int unsigned CLAMP_CYC   = `FSSS_CLAMP_CYC,
	parameter int unsigned PULSE_CYC   = `FSSS_RST_PULSE_CYC
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        supply_above_th_i,
	input  wire logic        battery_fail_flag_i,
	input  wire logic        vdd_undervoltage_i,
	input  wire logic        vdd_below_reset_th_i,
	input  wire logic        reset_pin_low_i,
	input  wire logic        bus_activity_i,
	input  wire logic        io1_level_i,
	input  wire logic        can_wake_i,
	input  wire logic        lin_wake_i,
	input  wire logic        io1_wake_en_i,
	input  wire logic [2:0]  debug_resistor_code_i,
	input  wire logic        init_done_i,
	input  wire logic        hold_wr_i,
	input  wire logic        hold_val_i,
	input  wire logic        second_pulse_sel_i,
	input  wire logic        uv_sel_low_i,
	input  wire logic        override_wr_i,
	input  wire logic [2:0]  override_code_i,
	input  wire logic        wd_refresh_ok_i,
	input  wire logic        safe_flags_clear_i,
	input  wire logic        spi_cmd_valid_i,
	input  wire logic [15:0] spi_cmd_i,
	output logic             vdd_enable_o,
	output logic             reset_n_o,
	output logic             safe_n_o,
	output logic [2:0]       safe_code_o,
	output logic             safe_flag_o,
	output logic             uv_sel_low_o,
	output fsss_state_t      state_o
);
	// two-flop synchronisers for every pin-level input
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] raw_w;
	logic [NSYNC-1:0] s1_r;
	logic [NSYNC-1:0] s2_r;
	assign raw_w = {supply_above_th_i, battery_fail_flag_i, vdd_undervoltage_i,
		vdd_below_reset_th_i, reset_pin_low_i, bus_activity_i, io1_level_i,
		can_wake_i, lin_wake_i};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge mclk_i or posedge rst_i) begin
				if (rst_i) begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= raw_w[gi];
					s2_r[gi] <= s1_r[gi];
				end
			end
		end
	endgenerate
	logic sup_ok_s, battery_fail_flag_s, uv_s, rth_s, rpin_s, act_s, io1_s, canw_s, linw_s;
	assign {sup_ok_s, battery_fail_flag_s, uv_s, rth_s, rpin_s, act_s, io1_s, canw_s, linw_s} = s2_r;

	fsss_state_t state_r;
	fsss_state_t state_nxt;
	logic        hold_r;
	logic [2:0]  code_r;
	logic        code_ovr_r;
	logic        vdd_en_r;
	logic        safe_r;
	logic        flag_r;
	logic        uv_sel_r;
	logic [31:0] wd_cnt_r;
	logic [31:0] pulse_cnt_r;
	logic [31:0] clamp_cnt_r;
	logic [3:0]  wd_fail_r;
	logic        wd_tick_w;
	logic        clamp_w;
	logic        in_pulse_w;
	logic        wake_w;
	logic        off_cond_w;
	logic        recover_w;
	logic        release_w;
	logic        pulse_safe_w;

	fsss_mon_if mon_if ();
	fsss_event_mon #(.IDLE_CYC(IDLE_CYC)) u_mon (
		.mclk_i         (mclk_i),
		.rst_i          (rst_i),
		.bus_activity_i (act_s),
		.io1_level_i    (io1_s),
		.m              (mon_if.mon)
	);
	assign mon_if.arm = (state_r == FSSS_ST_SAFE_ON);

	// hold bit
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			hold_r <= `FSSS_HOLD_RESET;
		else if (hold_wr_i)
			hold_r <= hold_val_i;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			uv_sel_r <= 1'b0;
		else
			uv_sel_r <= uv_sel_low_i; // threshold itself is analog
	end

	// safe-mode code: resistor sampled once at init exit, software wins
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			code_r     <= `FSSS_CODE_A;
			code_ovr_r <= 1'b0;
		end else if (override_wr_i) begin
			code_r     <= override_code_i;
			code_ovr_r <= 1'b1;
		end else if (state_r == FSSS_ST_INIT && init_done_i && !code_ovr_r) begin
			code_r <= debug_resistor_code_i;
		end
	end

	// watchdog period timer and 1 ms reset pulse
	assign wd_tick_w  = (wd_cnt_r == WD_PER_CYC - 1);
	assign in_pulse_w = (pulse_cnt_r != 32'h0);
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wd_cnt_r    <= 32'h0;
			pulse_cnt_r <= 32'h0;
		end else begin
			if (wd_refresh_ok_i || state_r == FSSS_ST_INIT || wd_tick_w)
				wd_cnt_r <= 32'h0;
			else
				wd_cnt_r <= wd_cnt_r + 32'h1;
			if (wd_tick_w && !wd_refresh_ok_i && state_r != FSSS_ST_INIT
				&& state_r != FSSS_ST_SAFE_OFF)
				pulse_cnt_r <= PULSE_CYC;
			else if (in_pulse_w)
				pulse_cnt_r <= pulse_cnt_r - 32'h1;
		end
	end

	// consecutive failures; saturates so evaluation is not re-triggered
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			wd_fail_r <= 4'h0;
		else if (wd_refresh_ok_i)
			wd_fail_r <= 4'h0;
		else if (wd_tick_w && state_r != FSSS_ST_INIT && wd_fail_r != `FSSS_WD_FAIL_LIMIT)
			wd_fail_r <= wd_fail_r + 4'h1;
	end

	// reset clamp deglitch
	assign clamp_w = (clamp_cnt_r >= CLAMP_CYC);
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			clamp_cnt_r <= 32'h0;
		else if (!rpin_s || !reset_n_o)
			clamp_cnt_r <= 32'h0; // own pulses are not a clamp
		else if (!clamp_w)
			clamp_cnt_r <= clamp_cnt_r + 32'h1;
	end

	assign pulse_safe_w = wd_tick_w && !wd_refresh_ok_i && state_r != FSSS_ST_INIT
		&& (second_pulse_sel_i ? (wd_fail_r >= 4'h1) : 1'b1);
	assign wake_w    = canw_s || linw_s || (io1_wake_en_i && io1_s);
	// a watchdog cause only ends with a refresh, otherwise safe would bounce straight out
	assign recover_w = wd_refresh_ok_i ||
		(!rth_s && !clamp_w && !uv_s && wd_fail_r != `FSSS_WD_FAIL_LIMIT);
	assign release_w = spi_cmd_valid_i && !flag_r &&
		(spi_cmd_i == `FSSS_REL_CMD0 || spi_cmd_i == `FSSS_REL_CMD1);

	always_comb begin
		case (code_r)
			`FSSS_CODE_B1: off_cond_w = mon_if.idle_expired;
			`FSSS_CODE_B2: off_cond_w = mon_if.pin_low_seen;
			`FSSS_CODE_B3: off_cond_w = mon_if.idle_expired && mon_if.pin_low_seen;
			default:       off_cond_w = 1'b0;
		endcase
	end

	// mode state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			FSSS_ST_INIT: begin
				if (init_done_i)
					state_nxt = FSSS_ST_NORMAL;
			end
			FSSS_ST_NORMAL, FSSS_ST_NREQ: begin
				if (rth_s || uv_s)
					state_nxt = FSSS_ST_RESET;
				else if (wd_tick_w && !wd_refresh_ok_i)
					state_nxt = FSSS_ST_RESET;
				else if (state_r == FSSS_ST_NREQ && wd_refresh_ok_i)
					state_nxt = FSSS_ST_NORMAL;
			end
			FSSS_ST_RESET: begin
				if (!in_pulse_w && !rth_s && !uv_s)
					state_nxt = FSSS_ST_NREQ;
			end
			FSSS_ST_SAFE_ON: begin
				if (recover_w)
					state_nxt = FSSS_ST_RESET;
				else if (off_cond_w)
					state_nxt = FSSS_ST_SAFE_OFF;
			end
			FSSS_ST_SAFE_OFF: begin
				if (wake_w)
					state_nxt = FSSS_ST_RESET;
			end
			default: state_nxt = FSSS_ST_RESET;
		endcase
		// failure evaluation overrides normal sequencing
		if ((state_r != FSSS_ST_SAFE_ON && state_r != FSSS_ST_SAFE_OFF
			&& state_r != FSSS_ST_INIT) &&
			(clamp_w || wd_fail_r == `FSSS_WD_FAIL_LIMIT))
			state_nxt = FSSS_ST_SAFE_ON;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			state_r <= FSSS_ST_INIT;
		else
			state_r <= state_nxt;
	end

	// safe pin and its flag; new cause wins over a clear in the same cycle
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			safe_r <= 1'b0;
			flag_r <= 1'b0;
		end else begin
			if (pulse_safe_w || rth_s || state_nxt == FSSS_ST_SAFE_ON) begin
				safe_r <= 1'b1;
				flag_r <= 1'b1;
			end else begin
				if (safe_flags_clear_i)
					flag_r <= 1'b0;
				if (release_w)
					safe_r <= 1'b0; // stays low through recovery
			end
		end
	end

	// supply switch
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			vdd_en_r <= 1'b0;
		else if (state_r == FSSS_ST_SAFE_OFF && !wake_w)
			vdd_en_r <= 1'b0;
		else if (state_r == FSSS_ST_SAFE_ON)
			vdd_en_r <= 1'b1;
		else if (hold_r)
			vdd_en_r <= battery_fail_flag_s ? 1'b0 : (vdd_en_r || sup_ok_s);
		else if (state_r == FSSS_ST_RESET && !sup_ok_s)
			vdd_en_r <= 1'b0;
		else if (sup_ok_s)
			vdd_en_r <= 1'b1;
	end

	assign vdd_enable_o = vdd_en_r;
	// reset and safe drop together on supply low
	assign reset_n_o    = !(state_r == FSSS_ST_RESET || in_pulse_w || rth_s);
	assign safe_n_o     = !(safe_r || rth_s);
	assign safe_code_o  = code_r;
	assign safe_flag_o  = flag_r;
	assign uv_sel_low_o = uv_sel_r;
	assign state_o      = state_r;
endmodule

// ---- bench/fsss_host_model.sv ----
// host micro model: watchdog service and safe pin release requests
`timescale 1ns/1ps
module fsss_host_model #(
	parameter int unsigned REFRESH_CYC = 10
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        vdd_enable_i,
	input  wire logic        reset_n_i,
	input  wire logic        refresh_en_i,
	input  wire logic        rel_req_i,
	input  wire logic        rel_clear_i,
	input  wire logic [15:0] rel_cmd_i,
	output logic             wd_refresh_ok_o,
	output logic             safe_flags_clear_o,
	output logic             spi_cmd_valid_o,
	output logic [15:0]      spi_cmd_o
);
	logic [7:0] cnt_r;
	logic       send;
	// a command goes out alone, or one cycle after the flag clear
	assign send = (rel_req_i && !rel_clear_i) || safe_flags_clear_o;
	// an unpowered or held micro cannot serve its watchdog
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 8'h00;
			wd_refresh_ok_o <= 1'b0;
		end else begin
			wd_refresh_ok_o <= cnt_r == 8'(REFRESH_CYC);
			cnt_r <= (vdd_enable_i && reset_n_i && refresh_en_i && cnt_r != 8'(REFRESH_CYC))
				? cnt_r + 8'h01 : 8'h00;
		end
	end
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			safe_flags_clear_o <= 1'b0;
			spi_cmd_valid_o <= 1'b0;
			spi_cmd_o <= 16'h0000;
		end else begin
			safe_flags_clear_o <= rel_req_i && rel_clear_i;
			spi_cmd_valid_o <= send;
			// idle data wanders so a stale word cannot pass for a command
			spi_cmd_o <= send ? rel_cmd_i : ~spi_cmd_o;
		end
	end
endmodule

// ---- bench/fsss_supervisor_sva.sv ----
// concurrent checks on the supply supervisor ports
`timescale 1ns/1ps
`include "fsss_cfg.svh"
module fsss_sup_sva import fsss_pkg::*; (
	input wire logic        mclk_i,
	input wire logic        rst_i,
	input wire logic        vdd_below_reset_th_i,
	input wire logic        io1_level_i,
	input wire logic        can_wake_i,
	input wire logic        spi_cmd_valid_i,
	input wire logic [15:0] spi_cmd_i,
	input wire logic        vdd_enable_o,
	input wire logic        reset_n_o,
	input wire logic        safe_n_o,
	input wire logic [2:0]  safe_code_o,
	input wire logic        safe_flag_o,
	input wire fsss_state_t state_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	// wake held long enough to pass the pin synchronisers
	sequence wake_s;
		state_o == FSSS_ST_SAFE_OFF && can_wake_i ##1 can_wake_i [*3];
	endsequence
	sequence wd_fall_s;
		$fell(reset_n_o) && !vdd_below_reset_th_i
			&& $past(state_o) inside {FSSS_ST_NORMAL, FSSS_ST_NREQ};
	endsequence
	safe_pin_low_a: assert property (
		state_o inside {FSSS_ST_SAFE_ON, FSSS_ST_SAFE_OFF} && $stable(state_o) |-> !safe_n_o)
		else $error("safe pin high in safe state");
	off_supply_a: assert property (
		state_o == FSSS_ST_SAFE_OFF && $stable(state_o) |-> !vdd_enable_o)
		else $error("supply on in safe off state");
	mode_a_on_a: assert property (
		state_o == FSSS_ST_SAFE_ON && $stable(state_o) && safe_code_o == `FSSS_CODE_A
		|-> vdd_enable_o) else $error("supply off in mode a");
	b2_pin_off_a: assert property (
		not (state_o == FSSS_ST_SAFE_ON && safe_code_o == `FSSS_CODE_B2 && !io1_level_i) [*8])
		else $error("b2 ignores low pin");
	wake_up_a: assert property (
		wake_s |-> ##[0:3] vdd_enable_o) else $error("wake did not restore supply");
	release_cmd_a: assert property (
		$rose(safe_n_o) |-> $past(spi_cmd_valid_i) && !$past(safe_flag_o)
			&& $past(spi_cmd_i) inside {`FSSS_REL_CMD0, `FSSS_REL_CMD1})
		else $error("safe pin released without command");
	low_supply_a: assert property (
		vdd_below_reset_th_i [*5] |-> !reset_n_o && !safe_n_o)
		else $error("low supply without reset and safe");
	pulse_width_a: assert property (
		wd_fall_s |-> !reset_n_o [*4] ##[1:2] reset_n_o)
		else $error("watchdog reset pulse length wrong");
endmodule

// ---- bench/fsss_supervisor_tb_top.sv ----
// self-checking bench for the supply supervisor
`timescale 1ns/1ps
`include "fsss_cfg.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR %s exp %0h got %0h", nm, exp, got); end end
module fsss_supervisor_tb_top import fsss_pkg::*;;
	localparam int WD = 40;
	localparam int IDLE = 50;
	logic        mclk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        bus_activity_i = 1'b0;
	logic        supply_above_th_i, battery_fail_flag_i, vdd_undervoltage_i, vdd_below_reset_th_i;
	logic        reset_pin_low_i, io1_level_i, can_wake_i, lin_wake_i, io1_wake_en_i, init_done_i;
	logic        hold_wr_i, hold_val_i, second_pulse_sel_i, uv_sel_low_i, override_wr_i;
	logic        wd_refresh_ok_i, safe_flags_clear_i, spi_cmd_valid_i;
	logic        vdd_enable_o, reset_n_o, safe_n_o, safe_flag_o, uv_sel_low_o;
	logic        refresh_en, rel_req, rel_clear, bus_run;
	logic [2:0]  debug_resistor_code_i, override_code_i, safe_code_o;
	logic [15:0] spi_cmd_i, rel_cmd;
	fsss_state_t state_o;
	int          err_count = 0;
	int          compares = 0;
	int          t, start, cyc_n = 0;
	fsss_supervisor #(.IDLE_CYC(IDLE), .WD_PER_CYC(WD), .CLAMP_CYC(20), .PULSE_CYC(4)) i_dut (
		.mclk_i, .rst_i, .supply_above_th_i, .battery_fail_flag_i, .vdd_undervoltage_i,
		.vdd_below_reset_th_i, .reset_pin_low_i, .bus_activity_i, .io1_level_i, .can_wake_i,
		.lin_wake_i, .io1_wake_en_i, .debug_resistor_code_i, .init_done_i, .hold_wr_i,
		.hold_val_i, .second_pulse_sel_i, .uv_sel_low_i, .override_wr_i, .override_code_i,
		.wd_refresh_ok_i, .safe_flags_clear_i, .spi_cmd_valid_i, .spi_cmd_i, .vdd_enable_o,
		.reset_n_o, .safe_n_o, .safe_code_o, .safe_flag_o, .uv_sel_low_o, .state_o);
	fsss_host_model i_host (.mclk_i, .rst_i, .vdd_enable_i(vdd_enable_o), .reset_n_i(reset_n_o),
		.refresh_en_i(refresh_en), .rel_req_i(rel_req), .rel_clear_i(rel_clear),
		.rel_cmd_i(rel_cmd), .wd_refresh_ok_o(wd_refresh_ok_i),
		.safe_flags_clear_o(safe_flags_clear_i), .spi_cmd_valid_o(spi_cmd_valid_i),
		.spi_cmd_o(spi_cmd_i));
	initial begin
		forever #12.5 mclk_i = ~mclk_i;
	end
	// toggling traffic keeps the idle timer from running out
	always @(posedge mclk_i) begin
		cyc_n++;
		bus_activity_i <= bus_run && !bus_activity_i;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic wrap_up();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [2:0] obs(input int sel);
		case (sel)
			0: obs = state_o;
			1: obs = {2'h0, vdd_enable_o};
			2: obs = {2'h0, reset_n_o};
			default: obs = {2'h0, safe_n_o};
		endcase
	endfunction
	task automatic wait_for(input int sel, input logic [2:0] v, input int lim);
		t = 0;
		while (obs(sel) !== v && t < lim) begin
			@(negedge mclk_i);
			t++;
		end
		`CHK("wait", v, obs(sel))
		if (obs(sel) !== v)
			wrap_up();
	endtask
	initial begin
		{supply_above_th_i, battery_fail_flag_i, vdd_undervoltage_i, vdd_below_reset_th_i} = 4'h0;
		{reset_pin_low_i, can_wake_i, lin_wake_i, io1_wake_en_i, init_done_i} = 5'h00;
		{hold_wr_i, hold_val_i, second_pulse_sel_i, uv_sel_low_i, override_wr_i} = 5'h00;
		{refresh_en, rel_req, rel_clear, bus_run} = 4'h0;
		io1_level_i = 1'b1;
		debug_resistor_code_i = `FSSS_CODE_B2;
		override_code_i = `FSSS_CODE_B1;
		rel_cmd = `FSSS_REL_CMD0;
		cyc(6);
		rst_i <= 1'b0;
		@(negedge mclk_i);
		`CHK("reset vdd", 1'b0, vdd_enable_o)
		`CHK("reset safe", 1'b1, safe_n_o)
		`CHK("reset code", `FSSS_CODE_A, safe_code_o)
		cyc(1);
		supply_above_th_i <= 1'b1;
		uv_sel_low_i <= 1'b1;
		hold_wr_i <= 1'b1;
		cyc(1);
		hold_wr_i <= 1'b0;
		wait_for(1, 3'h1, 10);
		`CHK("uv select", 1'b1, uv_sel_low_o)
		cyc(1);
		init_done_i <= 1'b1;
		cyc(1);
		init_done_i <= 1'b0;
		wait_for(0, FSSS_ST_NORMAL, 10);
		`CHK("latched code", `FSSS_CODE_B2, safe_code_o)
		cyc(1);
		override_wr_i <= 1'b1;
		refresh_en <= 1'b1;
		cyc(1);
		override_wr_i <= 1'b0;
		cyc(5 * WD);
		`CHK("override code", `FSSS_CODE_B1, safe_code_o)
		`CHK("refreshed", FSSS_ST_NORMAL, state_o)
		second_pulse_sel_i <= 1'b1;
		refresh_en <= 1'b0;
		start = cyc_n;
		wait_for(2, 3'h0, WD + 20);
		wait_for(2, 3'h1, 10);
		`CHK("first pulse safe", 1'b1, safe_n_o)
		wait_for(2, 3'h0, WD + 20);
		wait_for(2, 3'h1, 10);
		`CHK("second pulse safe", 1'b0, safe_n_o)
		cyc(1);
		bus_run <= 1'b1;
		wait_for(0, FSSS_ST_SAFE_ON, 10 * WD);
		`CHK("fail span", 1'b1, cyc_n - start >= 7 * WD && cyc_n - start <= 9 * WD + 20)
		cyc(3 * IDLE);
		`CHK("busy bus holds", FSSS_ST_SAFE_ON, state_o)
		bus_run <= 1'b0;
		wait_for(0, FSSS_ST_SAFE_OFF, 2 * IDLE);
		`CHK("idle span", 1'b1, t >= IDLE - 5)
		cyc(1);
		can_wake_i <= 1'b1;
		wait_for(1, 3'h1, 10);
		`CHK("wake safe low", 1'b0, safe_n_o)
		cyc(1);
		can_wake_i <= 1'b0;
		refresh_en <= 1'b1;
		cyc(4 * WD);
		`CHK("recovered safe low", 1'b0, safe_n_o)
		override_code_i <= `FSSS_CODE_A;
		override_wr_i <= 1'b1;
		reset_pin_low_i <= 1'b1;
		cyc(1);
		override_wr_i <= 1'b0;
		wait_for(0, FSSS_ST_SAFE_ON, 40);
		`CHK("clamp safe", 1'b0, safe_n_o)
		`CHK("mode a vdd", 1'b1, vdd_enable_o)
		reset_pin_low_i <= 1'b0;
		wait_for(0, FSSS_ST_NORMAL, 60);
		`CHK("clamp recovered safe low", 1'b0, safe_n_o)
		rel_req <= 1'b1;
		cyc(1);
		rel_req <= 1'b0;
		cyc(4);
		`CHK("release refused", 1'b0, safe_n_o)
		rel_clear <= 1'b1;
		rel_cmd <= `FSSS_REL_CMD1;
		rel_req <= 1'b1;
		cyc(1);
		rel_req <= 1'b0;
		wait_for(3, 3'h1, 10);
		cyc(1);
		vdd_below_reset_th_i <= 1'b1;
		wait_for(2, 3'h0, 6);
		`CHK("low supply safe", 1'b0, safe_n_o)
		supply_above_th_i <= 1'b0;
		wait_for(1, 3'h0, 6);
		hold_val_i <= 1'b1;
		hold_wr_i <= 1'b1;
		supply_above_th_i <= 1'b1;
		cyc(1);
		hold_wr_i <= 1'b0;
		wait_for(1, 3'h1, 6);
		supply_above_th_i <= 1'b0;
		cyc(6);
		`CHK("hold keeps vdd", 1'b1, vdd_enable_o)
		battery_fail_flag_i <= 1'b1;
		wait_for(1, 3'h0, 6);
		wrap_up();
	end
endmodule
bind fsss_supervisor fsss_sup_sva i_sva (.mclk_i, .rst_i, .vdd_below_reset_th_i, .io1_level_i,
	.can_wake_i, .spi_cmd_valid_i, .spi_cmd_i, .vdd_enable_o, .reset_n_o, .safe_n_o,
	.safe_code_o, .safe_flag_o, .state_o);
